/* rtl/asu_pkg.sv */
/*
 * shared constants and types for the asynchronous serial channel:
 * register offsets, field positions, reset values, enums and the
 * frame format carrier. assumes a 32-bit apb register bus.
 */
package asu_pkg;
    // register byte offsets
    localparam logic [7:0] ASU_OFS_MODE  = 8'h00;
    localparam logic [7:0] ASU_OFS_CTRL  = 8'h04;
    localparam logic [7:0] ASU_OFS_BRG   = 8'h08;
    localparam logic [7:0] ASU_OFS_TXBUF = 8'h0c;
    localparam logic [7:0] ASU_OFS_RXBUF = 8'h10;
    localparam logic [7:0] ASU_OFS_IRQ   = 8'h14;
    localparam logic [7:0] ASU_OFS_PORT  = 8'h18;
    // mode register fields
    localparam int ASU_MODE_LEN   = 0;
    localparam int ASU_MODE_EXT   = 3;
    localparam int ASU_MODE_STOP2 = 4;
    localparam int ASU_MODE_PODD  = 5;
    localparam int ASU_MODE_PEN   = 6;
    localparam int ASU_MODE_SLEEP = 7;
    localparam int ASU_MODE_OD    = 8;
    // control register fields
    localparam int ASU_CTRL_TXEN  = 0;
    localparam int ASU_CTRL_TBE   = 1;
    localparam int ASU_CTRL_RXEN  = 2;
    localparam int ASU_CTRL_TXEND = 3;
    localparam int ASU_CTRL_SRC   = 4;
    localparam int ASU_CTRL_CAUSE = 6;
    // receive buffer status fields
    localparam int ASU_RX_OVR = 12;
    localparam int ASU_RX_FER = 13;
    localparam int ASU_RX_PER = 14;
    localparam int ASU_RX_SUM = 15;
    localparam int ASU_RX_FUL = 16;
    // request and port fields
    localparam int ASU_IRQ_TX   = 0;
    localparam int ASU_IRQ_RX   = 1;
    localparam int ASU_PORT_OUT = 0;
    localparam int ASU_PORT_DIR = 1;
    localparam int ASU_PORT_PIN = 2;
    // reset values
    localparam logic [8:0] ASU_MODE_RST = 9'h000;
    localparam logic [7:0] ASU_BRG_RST  = 8'h00;
    // timing: sixteen oversampling ticks per bit, sample mid-bit
    localparam logic [3:0] ASU_OVS_LAST = 4'hf;
    localparam logic [3:0] ASU_SAMPLE   = 4'h7;
    localparam logic [4:0] ASU_DIV8_MSK = 5'h07;
    typedef enum logic [1:0] {ASU_LEN7 = 2'b00, ASU_LEN8 = 2'b01, ASU_LEN9 = 2'b10} asu_len_t;
    typedef enum logic [1:0] {ASU_SRC_DIV1 = 2'b00, ASU_SRC_DIV8 = 2'b01,
                              ASU_SRC_DIV32 = 2'b10, ASU_SRC_SUB = 2'b11} asu_src_t;
    typedef enum logic [1:0] {ASU_RX_IDLE = 2'b00, ASU_RX_START = 2'b01,
                              ASU_RX_BITS = 2'b10} asu_rx_state_t;
    // frame format shared by transmitter and receiver
    typedef struct packed {
        logic [1:0] len;
        logic       par_en;
        logic       par_odd;
        logic       stop2;
    } asu_fmt_t;
endpackage : asu_pkg

/* rtl/asu_baud.sv */
/*
 * bit rate generator: picks a source clock enable and divides it by
 * n+1, giving the sixteen-times oversampling tick. assumes all inputs
 * are synchronous to pclk.
 */
`timescale 1ns/1ps
module asu_baud import asu_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ext_sel,
    input  wire logic [1:0] src_sel,
    input  wire logic [7:0] divider,
    input  wire logic       subclock_source,
    input  wire logic       external_pin_clock,
    output logic            tick16
);
    logic [4:0] pre;       // prescaler for the divided system clocks
    logic       ext_q;     // last external clock level
    logic       selected_source_clock;
    logic [7:0] cnt;       // divider down counter

    // free running prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pre <= 5'h00;
        else pre <= pre + 5'h01;
    end

    // external clock edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ext_q <= 1'b0;
        else ext_q <= external_pin_clock;
    end

    // source select, sysclk_div1/8/32 or subclock
    always_comb begin
        if (ext_sel) selected_source_clock = external_pin_clock & ~ext_q;
        else begin
            case (asu_src_t'(src_sel))
                ASU_SRC_DIV1:  selected_source_clock = 1'b1;
                ASU_SRC_DIV8:  selected_source_clock = (pre & ASU_DIV8_MSK) == 5'h00;
                ASU_SRC_DIV32: selected_source_clock = pre == 5'h00;
                default:       selected_source_clock = subclock_source;
            endcase
        end
    end

    // divide by n+1; reload keeps a new n from waiting a full wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt    <= 8'h00;
            tick16 <= 1'b0;
        end else begin
            tick16 <= 1'b0;
            if (selected_source_clock) begin
                if (cnt == 8'h00) begin
                    cnt    <= divider;
                    tick16 <= 1'b1;
                end else cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : asu_baud

/* rtl/asu_tx.sv */
/*
 * transmit shifter: builds start, data, parity and stop bits into one
 * frame and shifts it out lsb first at one bit per sixteen ticks.
 * assumes load only while not busy.
 */
`timescale 1ns/1ps
module asu_tx import asu_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick16,
    input  wire logic       load,
    input  wire logic [8:0] data,
    input  wire asu_fmt_t   fmt,
    output logic            busy,
    output logic            done,
    output logic            txd
);
    logic [12:0] frame;    // remaining frame bits
    logic [12:0] next_frame;
    logic [3:0]  nbits;    // bits left in frame
    logic [3:0]  sub;      // oversample phase
    logic [3:0]  dlen;
    logic [8:0]  dmask;

    // assemble frame from data and format
    always_comb begin
        dlen  = 4'h7 + {2'b00, fmt.len};
        dmask = data & ~(9'h1ff << dlen);
        next_frame = 13'h1fff;
        next_frame[0] = 1'b0;
        next_frame[9:1] = dmask | (next_frame[9:1] & (9'h1ff << dlen));
        if (fmt.par_en) next_frame[dlen + 4'h1] = (^dmask) ^ fmt.par_odd;
    end

    // shift out, idle line stays high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame <= 13'h1fff;
            nbits <= 4'h0;
            sub   <= 4'h0;
            busy  <= 1'b0;
            done  <= 1'b0;
            txd   <= 1'b1;
        end else begin
            done <= 1'b0;
            if (load && !busy) begin
                frame <= next_frame;
                nbits <= dlen + 4'h2 + {3'b000, fmt.par_en} + {3'b000, fmt.stop2};
                sub   <= 4'h0;
                busy  <= 1'b1;
                txd   <= 1'b0;
            end else if (busy && tick16) begin
                sub <= sub + 4'h1;
                if (sub == ASU_OVS_LAST) begin
                    frame <= {1'b1, frame[12:1]};
                    nbits <= nbits - 4'h1;
                    txd   <= frame[1];
                    if (nbits == 4'h1) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        txd  <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : asu_tx

/* rtl/asu_top.sv */
/*
 * asynchronous serial channel top: apb register file, receiver and
 * transmit buffer control, with baud generator and transmit shifter.
 * assumes pins are synchronous to pclk and one apb master.
 */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module asu_top import asu_pkg::*; #(
    parameter bit HAS_EXT_CLK = 1'b1 // zero for the second serial channel
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe,
    input  wire logic        ext_baud_clock_pin_i,
    output logic             ext_baud_clock_pin_o,
    output logic             ext_baud_clock_pin_oe,
    input  wire logic        subclock_source,
    output logic             tx_irq_req,
    output logic             rx_irq_req
);
    ////////////////////////////////////////////////////////////////
    // declarations
    logic [8:0]    mode;      // format, clock and sleep settings
    logic          tx_en;     // transmit enable
    logic          rx_en;     // receive enable
    logic [1:0]    src_sel;   // internal source select
    logic          cause;     // transmit request cause
    logic [7:0]    brg;       // bit rate divider n
    logic [8:0]    txbuf;     // transmit buffer
    logic          tbe;       // transmit buffer empty
    logic [8:0]    rxbuf;     // receive buffer
    logic          rx_full;   // receive buffer unread
    logic          ovr;       // overrun error
    logic          fer;       // framing error
    logic          per;       // parity error
    logic [2:0]    port;      // clock pin as general port
    logic          wr;        // write strobe at completion
    logic          rd;        // read strobe at completion
    logic          tick16;    // oversample tick
    logic          tx_busy;   // shifter active
    logic          tx_done;   // shifter finished
    logic          txd;       // shifter line level
    logic          tx_load;   // buffer to shifter move
    logic          ext_sel;   // external clock in effect
    asu_fmt_t      fmt;       // frame format carrier
    logic [31:0]   rdata;     // read mux
    logic          mapped;    // address decodes
    asu_rx_state_t rx_state;  // receiver state
    logic [3:0]    rx_sub;    // oversample phase
    logic [3:0]    rx_idx;    // bits received after start
    logic [11:0]   rx_sh;     // collected bits
    logic [3:0]    rx_total;  // bits to collect after start
    logic [3:0]    dlen;      // data bit count
    logic          rx_end;    // last bit sampled this cycle
    logic [11:0]   fr;        // completed frame bits
    logic [8:0]    rx_data;   // masked character
    logic          rx_par;    // received parity bit
    logic          rx_fer;    // stop bit missing
    logic          rx_per;    // parity mismatch
    logic          rx_msb;    // character msb
    logic          rx_take;   // character accepted

    ////////////////////////////////////////////////////////////////
    // apb strobes and decode
    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;

    // word aligned decode of the map
    always_comb begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == ASU_OFS_MODE) rdata[8:0] = mode;
        else if (paddr == ASU_OFS_CTRL) begin
            rdata[ASU_CTRL_TXEN]     = tx_en;
            rdata[ASU_CTRL_TBE]      = tbe;
            rdata[ASU_CTRL_RXEN]     = rx_en;
            rdata[ASU_CTRL_TXEND]    = !tx_busy;
            rdata[ASU_CTRL_SRC +: 2] = src_sel;
            rdata[ASU_CTRL_CAUSE]    = cause;
        end
        else if (paddr == ASU_OFS_BRG) rdata[7:0] = brg;
        else if (paddr == ASU_OFS_TXBUF) rdata[8:0] = txbuf;
        else if (paddr == ASU_OFS_RXBUF) begin
            rdata[8:0]        = rxbuf;
            rdata[ASU_RX_OVR] = ovr;
            rdata[ASU_RX_FER] = fer;
            rdata[ASU_RX_PER] = per;
            rdata[ASU_RX_SUM] = ovr | fer | per;
            rdata[ASU_RX_FUL] = rx_full;
        end
        else if (paddr == ASU_OFS_IRQ) begin
            rdata[ASU_IRQ_TX] = tx_irq_req;
            rdata[ASU_IRQ_RX] = rx_irq_req;
        end
        else if (paddr == ASU_OFS_PORT) begin
            rdata[1:0]          = port[1:0];
            rdata[ASU_PORT_PIN] = ext_baud_clock_pin_i;
        end
        else mapped = 1'b0;
    end

    // one wait state: data and error latched in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= !mapped;
            end else pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode    <= ASU_MODE_RST;
            tx_en   <= 1'b0;
            rx_en   <= 1'b0;
            src_sel <= 2'b00;
            cause   <= 1'b0;
            brg     <= ASU_BRG_RST;
            port    <= 3'h0;
        end else if (wr) begin
            if (paddr == ASU_OFS_MODE) begin
                mode <= pwdata[8:0];
                // no clock pin on the second channel
                if (!HAS_EXT_CLK) mode[ASU_MODE_EXT] <= 1'b0;
            end
            else if (paddr == ASU_OFS_CTRL) begin
                tx_en   <= pwdata[ASU_CTRL_TXEN];
                rx_en   <= pwdata[ASU_CTRL_RXEN];
                src_sel <= pwdata[ASU_CTRL_SRC +: 2];
                cause   <= pwdata[ASU_CTRL_CAUSE];
            end
            else if (paddr == ASU_OFS_BRG) brg <= pwdata[7:0];
            else if (paddr == ASU_OFS_PORT) port <= {1'b0, pwdata[1:0]};
        end
    end

    assign ext_sel = mode[ASU_MODE_EXT] && HAS_EXT_CLK;
    assign fmt = '{len: mode[ASU_MODE_LEN +: 2], par_en: mode[ASU_MODE_PEN],
                   par_odd: mode[ASU_MODE_PODD], stop2: mode[ASU_MODE_STOP2]};

    ////////////////////////////////////////////////////////////////
    // clock pin: general port, or input when external clock chosen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_baud_clock_pin_o  <= 1'b0;
            ext_baud_clock_pin_oe <= 1'b0;
        end else begin
            ext_baud_clock_pin_o  <= port[ASU_PORT_OUT];
            ext_baud_clock_pin_oe <= port[ASU_PORT_DIR] && !ext_sel;
        end
    end

    // bit rate tick
    asu_baud u_baud (
        .pclk               (pclk),
        .presetn            (presetn),
        .ext_sel            (ext_sel),
        .src_sel            (src_sel),
        .divider            (brg),
        .subclock_source    (subclock_source),
        .external_pin_clock (ext_baud_clock_pin_i),
        .tick16             (tick16)
    );

    ////////////////////////////////////////////////////////////////
    // transmit buffer and requests
    assign tx_load = tx_en && !tbe && !tx_busy;

    // buffer write clears empty; move to shifter sets it again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf <= 9'h000;
            tbe   <= 1'b1;
        end else begin
            if (tx_load) tbe <= 1'b1;
            if (wr && paddr == ASU_OFS_TXBUF) begin
                txbuf <= pwdata[8:0];
                tbe   <= 1'b0;
            end
        end
    end

    // sticky requests, write one clears, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_irq_req <= 1'b0;
            rx_irq_req <= 1'b0;
        end else begin
            if (wr && paddr == ASU_OFS_IRQ) begin
                if (pwdata[ASU_IRQ_TX]) tx_irq_req <= 1'b0;
                if (pwdata[ASU_IRQ_RX]) rx_irq_req <= 1'b0;
            end
            if (!cause && tx_load) tx_irq_req <= 1'b1;
            if (cause && tx_done) tx_irq_req <= 1'b1;
            if (rx_take && !rx_full) rx_irq_req <= 1'b1;
        end
    end

    // frame shifter
    asu_tx u_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .tick16  (tick16),
        .load    (tx_load),
        .data    (txbuf),
        .fmt     (fmt),
        .busy    (tx_busy),
        .done    (tx_done),
        .txd     (txd)
    );

    // line driver; open drain only pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin_o  <= 1'b1;
            serial_out_pin_oe <= 1'b1;
        end else begin
            serial_out_pin_o  <= txd;
            serial_out_pin_oe <= mode[ASU_MODE_OD] ? !txd : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // receiver
    assign dlen     = 4'h7 + {2'b00, fmt.len};
    assign rx_total = dlen + 4'h1 + {3'b000, fmt.par_en} + {3'b000, fmt.stop2};
    assign rx_end   = rx_state == ASU_RX_BITS && tick16 && rx_sub == ASU_SAMPLE
                      && rx_idx == rx_total - 4'h1;

    // receive state machine, sampled mid-bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= ASU_RX_IDLE;
            rx_sub   <= 4'h0;
            rx_idx   <= 4'h0;
            rx_sh    <= 12'h000;
        end else if (!rx_en) rx_state <= ASU_RX_IDLE;
        else begin
            case (rx_state)
                ASU_RX_IDLE: begin
                    // low line while enabled is a start candidate
                    if (!serial_in_pin) begin
                        rx_state <= ASU_RX_START;
                        rx_sub   <= 4'h0;
                    end
                end
                ASU_RX_START: begin
                    if (tick16) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == ASU_SAMPLE) begin
                            // glitch shorter than half a bit is dropped
                            rx_state <= serial_in_pin ? ASU_RX_IDLE : ASU_RX_BITS;
                            rx_idx   <= 4'h0;
                        end
                    end
                end
                ASU_RX_BITS: begin
                    if (tick16) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == ASU_SAMPLE) begin
                            rx_sh[rx_idx] <= serial_in_pin;
                            rx_idx        <= rx_idx + 4'h1;
                            if (rx_end) rx_state <= ASU_RX_IDLE;
                        end
                    end
                end
                default: rx_state <= ASU_RX_IDLE;
            endcase
        end
    end

    // decode the completed frame, last bit merged in
    always_comb begin
        fr         = rx_sh;
        fr[rx_idx] = serial_in_pin;
        rx_data    = fr[8:0] & ~(9'h1ff << dlen);
        rx_par     = fr[dlen];
        rx_msb     = fr[dlen - 4'h1];
        rx_fer     = !fr[rx_total - 4'h1];
        if (fmt.stop2) rx_fer = rx_fer || !fr[rx_total - 4'h2];
        rx_per     = fmt.par_en && ((^rx_data) ^ rx_par ^ fmt.par_odd);
        rx_take    = rx_end && (!mode[ASU_MODE_SLEEP] || rx_msb);
    end

    // receive buffer and error flags; errors clear when disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxbuf   <= 9'h000;
            rx_full <= 1'b0;
            ovr     <= 1'b0;
            fer     <= 1'b0;
            per     <= 1'b0;
        end else begin
            if (rd && paddr == ASU_OFS_RXBUF) rx_full <= 1'b0;
            if (!rx_en) begin
                ovr <= 1'b0;
                fer <= 1'b0;
                per <= 1'b0;
            end
            if (rx_take) begin
                rxbuf   <= rx_data;
                rx_full <= 1'b1;
                fer     <= rx_fer;
                per     <= rx_per;
                if (rx_full) ovr <= 1'b1;
            end
        end
    end
endmodule : asu_top

/* test/asu_monitor.sv */
/* checker on the serial channel top ports
   assumes one pclk domain and asu_top to bind to */
`timescale 1ns/1ps
module asu_monitor import asu_pkg::*; (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       serial_out_pin_o,
    input wire logic       serial_out_pin_oe,
    input wire logic       tx_irq_req,
    input wire logic       rx_irq_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // any write to the request register may clear a flag
    wire clr = psel && penable && pready && pwrite && paddr == ASU_OFS_IRQ;
    // one wait state, then the answer
    sequence answer; !pready ##1 pready; endsequence
    // a bit holds for eight more cycles after it changes
    sequence bit_hold; $stable(serial_out_pin_o)[*8]; endsequence
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_wait: assert property ($rose(penable) && psel |-> answer) else $error("late");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_low_driven: assert property (!serial_out_pin_o |-> serial_out_pin_oe)
        else $error("low not driven");
    a_float_high: assert property (!serial_out_pin_oe |-> serial_out_pin_o)
        else $error("floating while low");
    a_bit_hold: assert property ($changed(serial_out_pin_o) |=> bit_hold)
        else $error("bit too short");
    a_rx_sticky: assert property (rx_irq_req && !clr |=> rx_irq_req)
        else $error("rx request lost");
    a_tx_sticky: assert property (tx_irq_req && !clr |=> tx_irq_req)
        else $error("tx request lost");
endmodule : asu_monitor
bind asu_top asu_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
    .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));

/* test/asu_remote.sv */
/* remote uart on the line: sends and captures frames
   assumes the bench sets bper and nbits to the device format */
`timescale 1ns/1ps
module asu_remote (
    input  wire logic pclk,
    input  wire logic line_in,
    output logic      line_out
);
    int          bper  = 16; // cycles per bit
    int          nbits = 10; // bits after start
    logic [11:0] got_q[$];   // captured frames
    logic [11:0] sh;         // capture shifter
    initial line_out = 1'b1; // idle high
    // capture: start on a low, sample each bit mid-way
    always begin
        @(posedge pclk iff line_in === 1'b0);
        sh = '0;
        repeat (bper / 2) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bper) @(posedge pclk);
            sh[i] = line_in;
        end
        got_q.push_back(sh);
    end
    // send: start bit, then bits lsb first, back to idle
    task automatic send(input logic [11:0] f, input int n);
        line_out <= 1'b0;
        repeat (bper) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            line_out <= f[i];
            repeat (bper) @(posedge pclk);
        end
        line_out <= 1'b1;
    endtask : send
endmodule : asu_remote

/* test/test_async_serial_uart_mode.sv */
/* self-checking bench for the serial channel top
   assumes asu_remote on the line and the bound checker */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_async_serial_uart_mode import asu_pkg::*; ;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ck_in = 0, er;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, so_o, so_oe, ck_o, ck_oe, tx_irq_req, rx_irq_req, rxd;
    logic [11:0] f, exp_q[$];
    logic [8:0]  d;
    int          n_errors = 0, check_count = 0, cyc = 0, fn, len, pm, s2, dv, c;
    wire         line = so_oe ? so_o : 1'b1; // pull-up on the wire
    always #12.5 pclk = ~pclk;
    asu_top #(.HAS_EXT_CLK(1'b1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(rxd), .serial_out_pin_o(so_o),
        .serial_out_pin_oe(so_oe), .ext_baud_clock_pin_i(ck_in), .ext_baud_clock_pin_o(ck_o),
        .ext_baud_clock_pin_oe(ck_oe), .subclock_source(1'b0), .tx_irq_req(tx_irq_req),
        .rx_irq_req(rx_irq_req));
    asu_remote r (.pclk(pclk), .line_in(line), .line_out(rxd));
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge pclk) penable <= 1;
        @(posedge pclk iff pready === 1'b1) begin rd = prdata; er = pslverr; end
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : apb
    // frame bits after the start bit, lsb first
    function automatic logic [11:0] frame(input logic [8:0] v, input int ln, p, s, bp, bs);
        logic [11:0] x;
        int          n;
        n = 7 + ln;
        x = v & ((12'h1 << n) - 12'h1);
        if (p != 0) begin
            x[n] = ^x ^ (p == 2) ^ bp[0];
            n++;
        end
        x[n] = !bs;
        x[n + 1] = s[0];
        fn = n + 1 + s;
        return x;
    endfunction : frame
    // receive one character and check the buffer word
    task automatic rx_one(input logic [8:0] v, input int bp, bs);
        f = frame(v, len, pm, s2, bp, bs);
        r.send(f, fn);
        wait (rx_irq_req === 1'b1);
        @(posedge pclk);
        apb(0, ASU_OFS_RXBUF, 0);
        `CHK("rxbuf", 32'(32'h10000 | (bp | bs) << 15 | bp << 14 | bs << 13 | v & ~(9'h1ff << (7 + len))), rd)
        apb(1, ASU_OFS_IRQ, 3);
    endtask : rx_one
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    always @(posedge pclk) if (++cyc == 60000) begin n_errors++; report_and_stop(); end
    initial begin
        void'($urandom(72));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, ASU_OFS_CTRL, 0); `CHK("ctrl", 32'ha, rd)
        apb(0, 8'h1c, 0); `CHK("unmapped", 2'b10, {er, rd[0]})
        // every length, parity and stop choice, both ways
        for (int i = 0; i < 18; i++) begin
            len = i % 3; pm = i / 3 % 3; s2 = i / 9; dv = i % 2; c = i / 2 % 2;
            r.bper = 16 * (dv + 1) * (i == 17 ? 8 : 1);
            apb(1, ASU_OFS_BRG, dv);
            apb(1, ASU_OFS_MODE, len | s2 << 4 | (pm == 2) << 5 | (pm != 0) << 6 | (i == 5) << 8);
            apb(1, ASU_OFS_CTRL, 5 | c << 6 | (i == 17) << 4);
            d = $urandom;
            exp_q.push_back(frame(d, len, pm, s2, 0, 0));
            r.nbits = fn;
            apb(1, ASU_OFS_TXBUF, d);
            repeat (4) @(posedge pclk);
            @(negedge pclk) `CHK("tx req", !c, tx_irq_req)
            wait (r.got_q.size() > 0);
            `CHK("tx frame", exp_q.pop_front(), r.got_q.pop_front())
            repeat (r.bper) @(posedge pclk);
            `CHK("tx done", 1'b1, tx_irq_req)
            rx_one($urandom, i == 4, i == 7);
            apb(1, ASU_OFS_CTRL, 0); // receive off clears error flags
        end
        // overrun: second character with the buffer unread
        r.bper = 16; len = 1; pm = 0; s2 = 0;
        apb(1, ASU_OFS_BRG, 0); apb(1, ASU_OFS_MODE, 1); apb(1, ASU_OFS_CTRL, 4);
        f = frame(9'h5a, 1, 0, 0, 0, 0); r.send(f, fn);
        apb(1, ASU_OFS_IRQ, 3);
        f = frame(9'hc3, 1, 0, 0, 0, 0); r.send(f, fn);
        repeat (8) @(posedge pclk);
        `CHK("ovr req", 1'b0, rx_irq_req)
        apb(0, ASU_OFS_RXBUF, 0); `CHK("ovr buf", 32'h190c3, rd)
        // receive off, then sleep with msb low and high
        for (int j = 0; j < 3; j++) begin
            apb(1, ASU_OFS_CTRL, 0); apb(1, ASU_OFS_MODE, 9'h81);
            apb(1, ASU_OFS_CTRL, (j > 0) << 2);
            f = frame(j == 1 ? 9'h35 : 9'hb5, 1, 0, 0, 0, 0); r.send(f, fn);
            repeat (8) @(posedge pclk);
            `CHK("sleep req", j == 2, rx_irq_req)
        end
        apb(0, ASU_OFS_RXBUF, 0); `CHK("sleep buf", 32'h100b5, rd)
        ck_in <= $urandom;
        apb(1, ASU_OFS_PORT, 3); apb(0, ASU_OFS_PORT, 0);
        `CHK("port", {ck_in, 4'hf}, {rd[2:0], ck_oe, ck_o})
        apb(1, ASU_OFS_MODE, 8); @(negedge pclk) `CHK("port ext", 1'b0, ck_oe)
        report_and_stop();
    end
endmodule : test_async_serial_uart_mode
